// ==== rtl/fram_host_ctrl.v ====
// Host controller driving an asynchronous 128K x 16 nonvolatile SRAM-style memory.
// Assumes dq_in is synchronous to clk; the board resolves dq from dq_out/dq_oe.
//
// What the document specifies
// RL1: Memory is 8x4096 rows of 4 columns.
// RL2: Chip enable fall latches address, starts read.
// RL3: Chip enable held high for precharge time.
// RL4: Byte selects gate which data lanes drive.
// RL5: Outputs float until valid or output enable high.
// RL6: Write enable low at fall means write.
// RL7: Late write enable fall floats device outputs.
// RL8: Upper address latched at chip enable fall.
// RL9: Write ends at first rising enable edge.
// RL10: Write held for access time, data stable.
// RL11: Column change gives page read word quickly.
// RL12: Extra write pulses give page-mode writes.
// RL13: Upper address change reprecharges and reaccesses.
// RL14: Eight 16K-word sectors, unprotected when shipped.
// RL15: Protection bit n covers sector n.
// RL16: Six fixed reads, three writes, one read.
// RL17: First write carries protection byte, low lane.
// RL18: Bit one protects, bit zero allows writes.
// RL19: Second write carries complement or sequence aborts.
// RL20: Out-of-order access restarts, protection unchanged.
// RL21: Sequence reads return normal array data.
// RL22: Finish with write 0FF00h, read 00000h.
// RL23: With chip enable low, access 00000h first.
// RL24: Only selected byte lanes get written.
// RL25: Protected sectors silently drop writes.
// RL26: Sequence advances on completed read/write cycles.
`timescale 1ns/1ps
`include "fram_host_defs.vh"

module fram_host_ctrl #(
  parameter ADDR_W = `ADDR_W,
  parameter DATA_W = `DATA_W
) (
  // Clock and reset
  input  wire              clk,
  input  wire              nrst,
  // User access port
  input  wire              req,
  input  wire              req_write,
  input  wire [ADDR_W-1:0] req_addr,
  input  wire [DATA_W-1:0] req_wdata,
  input  wire              req_high_n,
  input  wire              req_low_n,
  output reg               busy_ff,
  output reg               done_ff,
  output reg  [DATA_W-1:0] rdata_ff,
  // Protection update port
  input  wire              prot_req,
  input  wire [7:0]        prot_byte,
  output reg               prot_done_ff,
  // Memory pins
  output reg  [ADDR_W-1:0] mem_addr_ff,
  output reg               chip_en_n_ff,
  output reg               write_en_n_ff,
  output reg               out_en_n_ff,
  output reg               high_byte_sel_n_ff,
  output reg               low_byte_sel_n_ff,
  output reg  [DATA_W-1:0] dq_out_ff,
  output reg               dq_oe_ff,
  input  wire [DATA_W-1:0] dq_in
);

  // ==========================================================
  // Timing and states
  // Integer forms of the counts, cut to the counter width on purpose
  localparam integer ACC_CYC_I = `ACCESS_CYC;
  localparam integer PRE_CYC_I = `PRECHARGE_CYC;
  localparam [3:0]   ACC_CYC   = ACC_CYC_I[3:0];
  localparam [3:0]   PRE_CYC   = PRE_CYC_I[3:0];

  localparam [1:0] ST_IDLE   = 2'h0;
  localparam [1:0] ST_SETUP  = 2'h1;
  localparam [1:0] ST_ACCESS = 2'h2;
  localparam [1:0] ST_PRECH  = 2'h3;

  reg  [1:0]  state_ff;
  reg  [3:0]  cnt_ff;
  reg         is_write_ff;
  reg         seq_on_ff;
  reg  [3:0]  step_ff;
  reg  [7:0]  pbyte_ff;

  wire [16:0] seq_addr;
  wire        seq_write;
  wire [1:0]  seq_data_sel;

  // ==========================================================
  // Sequence table
  prot_seq_rom u_rom (
    .step         (step_ff),
    .seq_addr     (seq_addr),
    .seq_write    (seq_write),
    .seq_data_sel (seq_data_sel)
  );

  // Protection data rides the low lane only, upper lane zero
  function [DATA_W-1:0] seq_data;
    input [1:0] sel;
    input [7:0] pb;
    begin
      case (sel)
        `PDATA_BYTE: seq_data = {{(DATA_W-8){1'b0}}, pb};  // [RL17] [RL18]
        `PDATA_CPL:  seq_data = {{(DATA_W-8){1'b0}}, ~pb}; // [RL19]
        default:     seq_data = {DATA_W{1'b0}};
      endcase
    end
  endfunction

  // ==========================================================
  // Access engine
  // Every access toggles chip enable, so the sequence never enters
  // with chip enable low and no page or address-change cycles occur.
  // Trade: no page mode, so every word costs a full access and precharge.
  always @(posedge clk) begin
    if (!nrst) begin
      state_ff           <= ST_IDLE;
      cnt_ff             <= 4'h0;
      is_write_ff        <= 1'b0;
      seq_on_ff          <= 1'b0;
      step_ff            <= 4'h0;
      pbyte_ff           <= 8'h00;
      busy_ff            <= 1'b0;
      done_ff            <= 1'b0;
      prot_done_ff       <= 1'b0;
      rdata_ff           <= {DATA_W{1'b0}};
      mem_addr_ff        <= {ADDR_W{1'b0}};
      chip_en_n_ff       <= 1'b1;
      write_en_n_ff      <= 1'b1;
      out_en_n_ff        <= 1'b1;
      high_byte_sel_n_ff <= 1'b1;
      low_byte_sel_n_ff  <= 1'b1;
      dq_out_ff          <= {DATA_W{1'b0}};
      dq_oe_ff           <= 1'b0;
    end else begin
      done_ff      <= 1'b0;
      prot_done_ff <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          // Requests while busy are not seen; the user holds req to retry
          if (seq_on_ff) begin
            // Sequence steps run back to back, no user access between [RL20] [RL26]
            mem_addr_ff        <= seq_addr;                       // [RL16] [RL22]
            is_write_ff        <= seq_write;
            write_en_n_ff      <= ~seq_write;
            dq_out_ff          <= seq_data(seq_data_sel, pbyte_ff);
            dq_oe_ff           <= seq_write;
            high_byte_sel_n_ff <= 1'b0;
            low_byte_sel_n_ff  <= 1'b0;
            busy_ff            <= 1'b1;
            state_ff           <= ST_SETUP;
          end else if (req) begin
            mem_addr_ff        <= req_addr;
            is_write_ff        <= req_write;
            write_en_n_ff      <= ~req_write;                     // [RL6]
            dq_out_ff          <= req_wdata;
            dq_oe_ff           <= req_write;
            high_byte_sel_n_ff <= req_high_n;                     // [RL4] [RL24]
            low_byte_sel_n_ff  <= req_low_n;
            busy_ff            <= 1'b1;
            state_ff           <= ST_SETUP;
          end else if (prot_req) begin
            // Byte latched now; later moves of prot_byte are ignored
            seq_on_ff <= 1'b1;
            step_ff   <= 4'h0;
            pbyte_ff  <= prot_byte;
            busy_ff   <= 1'b1;
          end
        end
        ST_SETUP: begin
          // Address and write enable settled one cycle before the fall
          chip_en_n_ff <= 1'b0;                                    // [RL2] [RL8]
          // Output enable low only for reads, so a write never meets driven data
          out_en_n_ff  <= is_write_ff;
          cnt_ff       <= ACC_CYC - 4'h1;
          state_ff     <= ST_ACCESS;
        end
        ST_ACCESS: begin
          if (cnt_ff == 4'h0) begin
            // Full access time elapsed; write data stable since setup
            if (!is_write_ff)
              rdata_ff <= dq_in;                                   // [RL21]
            chip_en_n_ff <= 1'b1;                                  // [RL9] [RL10]
            out_en_n_ff  <= 1'b1;
            cnt_ff       <= PRE_CYC - 4'h1;
            state_ff     <= ST_PRECH;
          end else begin
            cnt_ff <= cnt_ff - 4'h1;
          end
        end
        ST_PRECH: begin
          // Chip enable already high, so these edges end nothing
          write_en_n_ff      <= 1'b1;
          dq_oe_ff           <= 1'b0;
          high_byte_sel_n_ff <= 1'b1;
          low_byte_sel_n_ff  <= 1'b1;
          if (cnt_ff == 4'h0) begin                                // [RL3] [RL23]
            state_ff <= ST_IDLE;
            if (seq_on_ff) begin
              if (step_ff == `PSEQ_LEN - 4'h1) begin
                seq_on_ff    <= 1'b0;
                busy_ff      <= 1'b0;
                prot_done_ff <= 1'b1;
              end
              step_ff <= step_ff + 4'h1;
            end else begin
              busy_ff <= 1'b0;
              done_ff <= 1'b1;
            end
          end else begin
            cnt_ff <= cnt_ff - 4'h1;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

endmodule // fram_host_ctrl

// ==== rtl/fram_host_defs.vh ====
// Constants for the host-side parallel memory controller.
// Assumes a 10 ns system clock; times are in ns, counts derived.
`ifndef FRAM_HOST_DEFS_VH
`define FRAM_HOST_DEFS_VH

// ==========================================================
// Clock and pin timing
`define CLK_PERIOD_NS       10
`define ACCESS_TIME_NS      60
`define PRECHARGE_TIME_NS   50
// Least times round up to whole cycles
`define ACCESS_CYC   ((`ACCESS_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PRECHARGE_CYC ((`PRECHARGE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ==========================================================
// Geometry
`define ADDR_W        17
`define DATA_W        16
`define SECTOR_MSB    16
`define SECTOR_LSB    14

// ==========================================================
// Protection sequence
`define PSEQ_LEN      4'hA
`define PSEQ_A0       17'h12555
`define PSEQ_A1       17'h1DAAA
`define PSEQ_A2       17'h01333
`define PSEQ_A3       17'h0ECCC
`define PSEQ_A4       17'h000FF
`define PSEQ_A5       17'h1FF00
`define PSEQ_A6       17'h1DAAA
`define PSEQ_A7       17'h0ECCC
`define PSEQ_A8       17'h0FF00
`define PSEQ_A9       17'h00000
// Data selector for sequence writes
`define PDATA_NONE    2'h0
`define PDATA_BYTE    2'h1
`define PDATA_CPL     2'h2

`endif

// ==== rtl/prot_seq_rom.v ====
// Step table of the sector write-protect command sequence.
// Pure lookup; the caller walks the step index.
`timescale 1ns/1ps
`include "fram_host_defs.vh"

module prot_seq_rom (
  // Step select
  input  wire [3:0]  step,
  // Entry
  output reg  [16:0] seq_addr,
  output reg         seq_write,
  output reg  [1:0]  seq_data_sel
);

  always @* begin
    seq_write    = 1'b0;
    seq_data_sel = `PDATA_NONE;
    case (step)
      4'h0: seq_addr = `PSEQ_A0;
      4'h1: seq_addr = `PSEQ_A1;
      4'h2: seq_addr = `PSEQ_A2;
      4'h3: seq_addr = `PSEQ_A3;
      4'h4: seq_addr = `PSEQ_A4;
      4'h5: seq_addr = `PSEQ_A5;
      4'h6: begin
        seq_addr     = `PSEQ_A6;
        seq_write    = 1'b1;
        seq_data_sel = `PDATA_BYTE;
      end
      4'h7: begin
        seq_addr     = `PSEQ_A7;
        seq_write    = 1'b1;
        seq_data_sel = `PDATA_CPL;
      end
      4'h8: begin
        seq_addr  = `PSEQ_A8;
        seq_write = 1'b1;
      end
      default: seq_addr = `PSEQ_A9;
    endcase
  end

endmodule // prot_seq_rom

// ==== verif/fram_host_chk_sva.sv ====
// Pin protocol checker for the host memory controller.
// Assumes a bind onto fram_host_ctrl; sees its ports only.
`timescale 1ns/1ps
module fram_host_chk (
  // Clock and reset
  input wire logic        clk,
  input wire logic        nrst,
  // Memory pins
  input wire logic [16:0] mem_addr_ff,
  input wire logic        chip_en_n_ff,
  input wire logic        write_en_n_ff,
  input wire logic        out_en_n_ff,
  input wire logic [15:0] dq_out_ff,
  input wire logic        dq_oe_ff,
  input wire logic [15:0] dq_in,
  // Status
  input wire logic [15:0] rdata_ff,
  input wire logic        done_ff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // ==========================================================
  // Pin timing
  precharge_hold_a: assert property ($rose(chip_en_n_ff) |-> chip_en_n_ff[*5])
    else $error("precharge too short");
  access_hold_a: assert property ($fell(chip_en_n_ff) |-> !chip_en_n_ff[*6])
    else $error("access too short");
  wdata_hold_a: assert property (!chip_en_n_ff && !write_en_n_ff |-> dq_oe_ff && $stable(dq_out_ff))
    else $error("write data moved");
  ce_write_a: assert property ($fell(write_en_n_ff) |-> chip_en_n_ff)
    else $error("write enable fell in cycle");
  oe_quiet_a: assert property (!write_en_n_ff |-> out_en_n_ff)
    else $error("output enable in write");
  no_fight_a: assert property (!out_en_n_ff |-> !dq_oe_ff)
    else $error("bus contention");
  addr_hold_a: assert property (!chip_en_n_ff |-> $stable(mem_addr_ff))
    else $error("address moved");
  read_take_a: assert property ($rose(chip_en_n_ff) && write_en_n_ff |-> rdata_ff == $past(dq_in))
    else $error("read data not taken");
  done_late_a: assert property (done_ff |-> !$past(chip_en_n_ff, 6) && $past(chip_en_n_ff, 5))
    else $error("done before precharge");
endmodule // fram_host_chk

bind fram_host_ctrl fram_host_chk i_chk (.clk, .nrst, .mem_addr_ff, .chip_en_n_ff, .write_en_n_ff,
  .out_en_n_ff, .dq_out_ff, .dq_oe_ff, .dq_in, .rdata_ff, .done_ff);

// ==== verif/fram_dev_model.sv ====
// Behavioural model of the asynchronous nonvolatile word memory.
// Assumes the bench resolves the data bus and feeds it back on dq.
`timescale 1ns/1ps
module fram_dev_model (
  // Control pins
  input  wire logic [16:0] addr,
  input  wire logic        ce_n,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic        hb_n,
  input  wire logic        lb_n,
  // Data
  input  wire logic [15:0] dq,
  output wire logic [15:0] dq_drv
);
  // ==========================================================
  // Array and protection state
  logic [15:0] mem [0:131071];
  logic [16:0] seq [0:9] = '{17'h12555, 17'h1DAAA, 17'h01333, 17'h0ECCC, 17'h000FF,
                             17'h1FF00, 17'h1DAAA, 17'h0ECCC, 17'h0FF00, 17'h00000};
  logic [16:0] lat_a = 17'h00000;
  logic [7:0]  prot  = 8'h00;
  logic [7:0]  pend  = 8'h00;
  logic [3:0]  st    = 4'h0;
  logic        ready = 1'b0;
  logic        hit;
  wire         rd_ok = !ce_n && !oe_n && we_n && ready;
  wire  [15:0] word  = mem[lat_a];
  // Released lanes show the inverse, so a stale sample never matches
  assign dq_drv = {(rd_ok && !hb_n) ? word[15:8] : ~word[15:8],
                   (rd_ok && !lb_n) ? word[7:0] : ~word[7:0]};
  initial for (int i = 0; i < 131072; i++) mem[i] = i[15:0] ^ 16'h5A5A;
  always @(negedge ce_n) begin
    lat_a = addr;
    ready = 1'b0;
    ready <= #59.5 1'b1;
  end
  // Address moves under a low chip enable: column only is a page access, else the row reopens
  always @(addr) if (!ce_n) begin
    ready = 1'b0;
    ready <= #((addr[16:2] == lat_a[16:2]) ? 24.5 : 109.5) 1'b1;
    lat_a = addr;
  end
  always @(negedge we_n) if (!ce_n) lat_a[1:0] = addr[1:0];
  // Cycle ends at chip enable rise; write enable level classifies it
  always @(posedge ce_n) begin
    ready = 1'b0;
    hit = (lat_a == seq[st]) && (!we_n == (st > 4'h5 && st < 4'h9));
    if (!we_n && !(hit && st > 4'h5) && !prot[lat_a[16:14]]) begin
      if (!hb_n) mem[lat_a][15:8] = dq[15:8];
      if (!lb_n) mem[lat_a][7:0] = dq[7:0];
    end
    if (hit && st == 4'h6) pend = dq[7:0];
    if (hit && st == 4'h7 && dq[7:0] == ~pend) prot = pend;
    if (hit && st != 4'h9 && !(st == 4'h7 && dq[7:0] != ~pend)) st = st + 4'h1;
    else st = (lat_a == seq[0] && we_n) ? 4'h1 : 4'h0;
  end
endmodule // fram_dev_model

// ==== verif/tb_fram_host_ctrl.sv ====
// Self-checking bench for the host memory controller.
// Assumes the device model on the far side and the bound checker.
`timescale 1ns/1ps
module tb_fram_host_ctrl;
  logic        clk = 1'b0, nrst = 1'b0, req = 1'b0, req_write = 1'b0, prot_req = 1'b0;
  logic        req_high_n = 1'b0, req_low_n = 1'b0;
  logic [16:0] req_addr = 17'h00000;
  logic [15:0] req_wdata = 16'h0000;
  logic [7:0]  prot_byte = 8'h00;
  wire         busy_ff, done_ff, prot_done_ff, chip_en_n_ff, write_en_n_ff, out_en_n_ff, dq_oe_ff;
  wire         high_byte_sel_n_ff, low_byte_sel_n_ff;
  wire  [16:0] mem_addr_ff;
  wire  [15:0] rdata_ff, dq_out_ff, dq_drv;
  wire  [15:0] dq_in = dq_oe_ff ? dq_out_ff : dq_drv;
  int          fail_count = 0;
  int          comparisons = 0;
  always #5 clk = ~clk;
  fram_host_ctrl i_dut (.clk, .nrst, .req, .req_write, .req_addr, .req_wdata, .req_high_n, .req_low_n,
    .busy_ff, .done_ff, .rdata_ff, .prot_req, .prot_byte, .prot_done_ff, .mem_addr_ff, .chip_en_n_ff,
    .write_en_n_ff, .out_en_n_ff, .high_byte_sel_n_ff, .low_byte_sel_n_ff, .dq_out_ff, .dq_oe_ff, .dq_in);
  fram_dev_model i_mem (.addr(mem_addr_ff), .ce_n(chip_en_n_ff), .we_n(write_en_n_ff), .oe_n(out_en_n_ff),
    .hb_n(high_byte_sel_n_ff), .lb_n(low_byte_sel_n_ff), .dq(dq_in), .dq_drv(dq_drv));
  // ==========================================================
  // Shared tasks
  function automatic logic [15:0] pat(input logic [16:0] a);
    return a[15:0] ^ 16'h5A5A;
  endfunction
  task automatic test_done;
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Request is dropped once taken so it is not accepted twice
  task automatic acc(input logic w, input logic [16:0] a, input logic [15:0] d, input logic hn, input logic ln);
    int n;
    @(negedge clk);
    {req, req_write, req_addr, req_wdata, req_high_n, req_low_n} = {1'b1, w, a, d, hn, ln};
    @(negedge clk);
    req = 1'b0;
    chk({15'h0000, busy_ff}, 16'h0001);
    for (n = 0; n < 40 && done_ff !== 1'b1; n++) @(negedge clk);
    if (n == 40) begin
      fail_count++;
      test_done;
    end
    chk(n[15:0], 16'h000C);
    chk({15'h0000, busy_ff}, 16'h0000);
  endtask
  task automatic protect(input logic [7:0] b);
    int n;
    @(negedge clk);
    {prot_req, prot_byte} = {1'b1, b};
    @(negedge clk);
    prot_req = 1'b0;
    for (n = 0; n < 400 && prot_done_ff !== 1'b1; n++) @(negedge clk);
    if (n == 400) begin
      fail_count++;
      test_done;
    end
    chk(n[15:0], 16'h0082);
    chk(rdata_ff, pat(17'h00000));
  endtask
  // ==========================================================
  // Scenarios
  task automatic lanes;
    acc(1'b1, 17'h04001, 16'h1234, 1'b0, 1'b0);
    acc(1'b0, 17'h04001, 16'h0000, 1'b0, 1'b0);
    chk(rdata_ff, 16'h1234);
    acc(1'b1, 17'h04001, 16'hABCD, 1'b0, 1'b1);
    acc(1'b1, 17'h04002, 16'hEF56, 1'b1, 1'b0);
    acc(1'b0, 17'h04001, 16'h0000, 1'b0, 1'b0);
    chk(rdata_ff, 16'hAB34);
    acc(1'b0, 17'h04002, 16'h0000, 1'b1, 1'b0);
    chk({8'h00, rdata_ff[7:0]}, 16'h0056);
    $display("lane test done");
  endtask
  task automatic sect(input logic [7:0] b, input logic [15:0] d);
    logic [16:0] a [0:3] = '{17'h03FFF, 17'h0C000, 17'h13FFF, 17'h1C000};
    protect(b);
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, a[i], d, 1'b0, 1'b0);
      acc(1'b0, a[i], 16'h0000, 1'b0, 1'b0);
      chk(rdata_ff, b[a[i][16:14]] ? pat(a[i]) : d);
    end
    $display("sector test done");
  endtask
  initial begin
    repeat (5) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    lanes;
    sect(8'h89, 16'hC0DE);
    sect(8'h00, 16'h7E11);
    test_done;
  end
endmodule // tb_fram_host_ctrl
